// [core/afr_ctrl.v]
`timescale 1ns/1ns
`include "afr_consts.vh"
// Operation
// - one bit switches both burnout generators
// - zero on burnout bit turns both off
// - excitation magnitude small, middle or large
// - excitation enable, pin steering, magnitude select
// - bias only to first three negative inputs
// - bias_fast_power_up bit raises bias generator current
// - reference select internal or two external
// - detect only when enabled and external
// - low or open reference sets missing flag
// - missing flag forces results all ones
// - missing flag blocks calibration, sets error
// - thirty-two ones reset everything but data_out and cal_wr_data, and pulse soft_rst
// - same reset at power up, which also clears data_out and cal_wr_data
// - supply monitor uses internal reference
// - good calibration updates, readies, goes idle
module afr_ctrl #(
   parameter DW = 24
) (
   input  wire          clk,            // 10 MHz clock
   input  wire          arst_n,         // power-up reset, active low
   input  wire          ce,             // clock enable
   input  wire          sdi_vld,        // serial bit strobe
   input  wire          sdi_bit,        // serial data bit
   input  wire          cfg_wr,         // load configuration pulse
   input  wire          burnout_enable, // burnout request
   input  wire          exc_en_in,      // excitation enable
   input  wire          exc_pin_in,     // 0 pin a, 1 pin b
   input  wire [1:0]    exc_mag_in,     // excitation magnitude
   input  wire          bias_select_hi, // bias field high bit
   input  wire          bias_select_lo, // bias field low bit
   input  wire          bias_fast_power_up, // bias_fast_power_up request
   input  wire          reference_source_hi, // ref field high
   input  wire          reference_source_lo, // ref field low
   input  wire          reference_check_enable, // detect enable
   input  wire          channel_select_hi, // channel field high
   input  wire [1:0]    channel_select_lo, // channel field low
   input  wire          ref_low_a,      // pair a below threshold/open
   input  wire          ref_low_b,      // pair b below threshold/open
   input  wire          conv_done,      // conversion result pulse
   input  wire [DW-1:0] conv_data,      // raw result
   input  wire          cal_start,      // calibration begins
   input  wire          cal_done,       // calibration ends
   input  wire [DW-1:0] cal_coef,       // measured coefficient
   output reg           bo_src_on,      // positive input source on
   output reg           bo_sink_on,     // negative input sink on
   output reg           exc_a_on,       // current_out_pin_a drive
   output reg           exc_b_on,       // current_out_pin_b drive
   output reg  [1:0]    exc_mag,        // excitation magnitude
   output reg  [2:0]    bias_neg_sel,   // one-hot neg terminal bias
   output reg           bias_bias_fast_power_up,     // boosted bias current
   output reg  [1:0]    mod_ref_sel,    // reference fed to modulator
   output reg           supply_mon_on,  // supply divider on
   output reg           missing_reference_flag, // no valid ref
   output reg           err_flag,       // calibration error
   output reg           rdy_n,          // ready, active low
   output reg           data_vld,       // result pulse
   output reg  [DW-1:0] data_out,       // result to data register
   output reg           cal_wr,         // coefficient write pulse
   output reg  [DW-1:0] cal_wr_data,    // coefficient value
   output reg           soft_rst        // serial reset pulse
);
   // ------------------------------------------------------------
   // local state
   // ------------------------------------------------------------
   localparam ST_IDLE = 1'b0; // no calibration running
   localparam ST_CAL  = 1'b1; // calibration in progress
   reg       state_reg;        // calibration state
   reg       cal_bad_reg;      // ref lost during calibration
   reg       bo_reg;           // burnout control bit
   reg [1:0] ref_reg;          // reference source field
   reg [2:0] ch_reg;           // channel field
   reg       det_reg;          // detect enable bit
   wire      pat_hit;          // 32 ones seen
   wire [1:0] bias_f = {bias_select_hi, bias_select_lo};
   wire       ext_sel;         // external source in use
   wire       ref_bad;         // detector says missing

   // ------------------------------------------------------------
   // serial pattern reset detector
   // ------------------------------------------------------------
   afr_ones_det #(
      .CW (`AFR_ONES_W)
   ) u_ones (
      .clk     (clk),
      .arst_n  (arst_n),
      .ce      (ce),
      .bit_vld (sdi_vld),
      .bit_val (sdi_bit),
      .hit     (pat_hit)
   );

   // ------------------------------------------------------------
   // reference detect decode
   // ------------------------------------------------------------
   // supply monitor always runs on internal ref, so no detection
   // codes 2 and 3 both mean internal; only the two pairs are checked
   assign ext_sel = ((ref_reg == `AFR_REF_EXT_A) ||
                     (ref_reg == `AFR_REF_EXT_B)) &&
                    (ch_reg != `AFR_CH_SUPPLY_MON);
   assign ref_bad = det_reg && ext_sel &&
                    ((ref_reg == `AFR_REF_EXT_A) ? ref_low_a
                                                 : ref_low_b);

   // ------------------------------------------------------------
   // main control process; pattern reset acts like power-up except for data_out, cal_wr_data and the soft_rst pulse
   // ------------------------------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bo_reg      <= `AFR_RST_BURNOUT;
         ref_reg     <= `AFR_RST_REFSRC;
         ch_reg      <= `AFR_RST_CHAN;
         det_reg     <= 1'b0;
         state_reg   <= ST_IDLE;
         cal_bad_reg <= 1'b0;
         bo_src_on   <= 1'b0;
         bo_sink_on  <= 1'b0;
         exc_a_on    <= 1'b0;
         exc_b_on    <= 1'b0;
         exc_mag     <= `AFR_EXC_SMALL;
         bias_neg_sel <= 3'h0;
         bias_bias_fast_power_up  <= 1'b0;
         mod_ref_sel <= `AFR_RST_REFSRC;
         supply_mon_on <= 1'b0;
         missing_reference_flag <= 1'b0;
         err_flag    <= 1'b0;
         rdy_n       <= 1'b1;
         data_vld    <= 1'b0;
         data_out    <= {DW{1'b0}};
         cal_wr      <= 1'b0;
         cal_wr_data <= {DW{1'b0}};
         soft_rst    <= 1'b0;
      end else if (ce) begin
         data_vld <= 1'b0;
         cal_wr   <= 1'b0;
         soft_rst <= pat_hit;
         if (pat_hit) begin
            // every register but data_out, cal_wr_data and soft_rst back to its default
            bo_reg      <= `AFR_RST_BURNOUT;
            ref_reg     <= `AFR_RST_REFSRC;
            ch_reg      <= `AFR_RST_CHAN;
            det_reg     <= 1'b0;
            state_reg   <= ST_IDLE;
            cal_bad_reg <= 1'b0;
            bo_src_on   <= 1'b0;
            bo_sink_on  <= 1'b0;
            exc_a_on    <= 1'b0;
            exc_b_on    <= 1'b0;
            exc_mag     <= `AFR_EXC_SMALL;
            bias_neg_sel <= 3'h0;
            bias_bias_fast_power_up  <= 1'b0;
            mod_ref_sel <= `AFR_RST_REFSRC;
            supply_mon_on <= 1'b0;
            missing_reference_flag <= 1'b0;
            err_flag    <= 1'b0;
            rdy_n       <= 1'b1;
         end else begin
            // configuration load
            if (cfg_wr) begin
               bo_reg  <= burnout_enable;
               ref_reg <= {reference_source_hi, reference_source_lo};
               ch_reg  <= {channel_select_hi, channel_select_lo};
               det_reg <= reference_check_enable;
               // both generators share one bit, zero turns both off
               bo_src_on  <= burnout_enable;
               bo_sink_on <= burnout_enable;
               exc_a_on <= exc_en_in && (exc_pin_in == `AFR_EXC_PIN_A);
               exc_b_on <= exc_en_in && (exc_pin_in != `AFR_EXC_PIN_A);
               // reserved magnitude code falls back to smallest
               exc_mag <= (exc_mag_in > `AFR_EXC_LARGE) ?
                          `AFR_EXC_SMALL : exc_mag_in;
               // only the first three negative inputs can be biased
               case (bias_f)
                  2'h1:    bias_neg_sel <= 3'h1;
                  2'h2:    bias_neg_sel <= 3'h2;
                  2'h3:    bias_neg_sel <= 3'h4;
                  default: bias_neg_sel <= 3'h0;
               endcase
               bias_bias_fast_power_up <= bias_fast_power_up;
               if ({channel_select_hi, channel_select_lo} ==
                   `AFR_CH_SUPPLY_MON) begin
                  mod_ref_sel   <= `AFR_REF_INTERNAL;
                  supply_mon_on <= 1'b1;
               end else begin
                  mod_ref_sel   <= {reference_source_hi,
                                    reference_source_lo};
                  supply_mon_on <= 1'b0;
               end
            end
            // flag tracks detector, clears on its own
            missing_reference_flag <= ref_bad;
            // conversion result path
            if (conv_done && state_reg == ST_IDLE) begin
               data_vld <= 1'b1;
               rdy_n    <= 1'b0;
               data_out <= missing_reference_flag ?
                           {DW{1'b1}} : conv_data;
            end
            // calibration sequencing
            case (state_reg)
               ST_IDLE: begin
                  if (cal_start) begin
                     state_reg   <= ST_CAL;
                     cal_bad_reg <= 1'b0;
                     rdy_n       <= 1'b1;
                     err_flag    <= 1'b0;
                  end
               end
               default: begin
                  if (missing_reference_flag) begin
                     cal_bad_reg <= 1'b1;
                  end
                  if (cal_done) begin
                     state_reg <= ST_IDLE;
                     rdy_n     <= 1'b0;
                     if (cal_bad_reg || missing_reference_flag) begin
                        err_flag <= 1'b1;
                     end else begin
                        cal_wr      <= 1'b1;
                        cal_wr_data <= cal_coef;
                     end
                  end
               end
            endcase
         end
      end
   end
endmodule

// [pkg/afr_consts.vh]
`ifndef AFR_CONSTS_VH
`define AFR_CONSTS_VH
// ----------------------------------------------------------------
// reference source codes
// ----------------------------------------------------------------
`define AFR_REF_EXT_A     2'h0
`define AFR_REF_EXT_B     2'h1
`define AFR_REF_INTERNAL  2'h2
// ----------------------------------------------------------------
// channel and bias codes
// ----------------------------------------------------------------
`define AFR_CH_SUPPLY_MON 3'h7
`define AFR_BIAS_OFF      2'h0
// ----------------------------------------------------------------
// excitation magnitude and routing codes
// ----------------------------------------------------------------
`define AFR_EXC_SMALL     2'h0
`define AFR_EXC_MIDDLE    2'h1
`define AFR_EXC_LARGE     2'h2
`define AFR_EXC_PIN_A     1'h0
// ----------------------------------------------------------------
// serial reset pattern length
// ----------------------------------------------------------------
`define AFR_RESET_ONES    32
`define AFR_ONES_W        6
// ----------------------------------------------------------------
// reset values of the control bits
// ----------------------------------------------------------------
`define AFR_RST_BURNOUT   1'h0
`define AFR_RST_REFSRC    2'h0
`define AFR_RST_CHAN      3'h0
`endif

// [core/afr_ones_det.v]
`timescale 1ns/1ns
`include "afr_consts.vh"
// counts consecutive ones on the sampled serial data input
module afr_ones_det #(
   parameter CW = `AFR_ONES_W
) (
   input  wire clk,      // system clock
   input  wire arst_n,   // async reset, active low
   input  wire ce,       // clock enable
   input  wire bit_vld,  // one serial bit this cycle
   input  wire bit_val,  // value of that bit
   output reg  hit       // pulse: pattern complete
);
   reg [CW-1:0] cnt_reg; // run length of ones

   // ------------------------------------------------------------
   // run counter
   // ------------------------------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= {CW{1'b0}};
         hit     <= 1'b0;
      end else if (ce) begin
         hit <= 1'b0;
         if (bit_vld) begin
            if (!bit_val) begin
               cnt_reg <= {CW{1'b0}};
            end else if (cnt_reg == `AFR_RESET_ONES - 1) begin
               cnt_reg <= {CW{1'b0}};
               hit     <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule

// [sim/afr_ctrl_sva.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------
// port checker for the front-end control block
// ----------------------------------------------------------
module afr_ctrl_sva #(
   parameter DW = 24
) (
   input wire          clk, arst_n, ce, cfg_wr,  // clock, reset, load
   input wire          burnout_enable, reference_check_enable, // config
   input wire          reference_source_hi, reference_source_lo, // ref
   input wire          channel_select_hi,        // channel high bit
   input wire [1:0]    channel_select_lo,        // channel low bits
   input wire          sdi_vld, sdi_bit, ref_low_a, ref_low_b, // events
   input wire          conv_done, cal_start, cal_done, soft_rst, // pulses
   input wire [DW-1:0] conv_data, cal_coef, data_out, cal_wr_data, // data
   input wire          bo_src_on, bo_sink_on, supply_mon_on, // drives
   input wire [1:0]    mod_ref_sel,              // modulator reference
   input wire          missing_reference_flag, err_flag, rdy_n, // status
   input wire          data_vld, cal_wr          // strobes
);
   reg [1:0] src_reg;                            // stored ref source
   reg       det_reg, sup_reg, busy_reg, seen_reg; // stored state
   reg [5:0] ones_reg;                           // consecutive ones
   reg       hit_d;                              // pattern seen last edge
   // the pattern ends on the 32nd one; the block clears one edge later
   wire hit = ce && sdi_vld && sdi_bit && (ones_reg == 6'h1f);
   // detector verdict for the stored source; internal ref never fails
   wire bad = det_reg && !sup_reg &&
              (src_reg == 2'h0 ? ref_low_a : src_reg == 2'h1 && ref_low_b);
   // ----------------------------------------------------------
   // shadow of the stored fields, kept in step with the block
   // ----------------------------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         {src_reg, det_reg, sup_reg, busy_reg, seen_reg, ones_reg} <= 'h0;
         hit_d <= 1'b0;
      end else if (ce) begin
         hit_d <= hit;
         // the run counter restarts on the 32nd one itself
         if (sdi_vld) ones_reg <= (sdi_bit && !hit) ? ones_reg + 6'h1 : 6'h0;
         if (hit_d) begin
            {src_reg, det_reg, sup_reg, busy_reg, seen_reg} <= 'h0;
         end else begin
            if (cfg_wr) src_reg <= {reference_source_hi, reference_source_lo};
            if (cfg_wr) det_reg <= reference_check_enable;
            if (cfg_wr) sup_reg <= &{channel_select_hi, channel_select_lo};
            if (!busy_reg && cal_start) busy_reg <= 1'b1;
            else if (busy_reg && cal_done) busy_reg <= 1'b0;
            if (!busy_reg && cal_start) seen_reg <= 1'b0;
            else if (busy_reg && missing_reference_flag) seen_reg <= 1'b1;
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_cfg; ce && cfg_wr && !hit_d; endsequence
   sequence s_cal_end; ce && cal_done && busy_reg && !hit_d; endsequence
   sequence s_cal_go; ce && cal_start && !busy_reg && !hit_d; endsequence
   property p_bo;
      s_cfg |=> bo_src_on == $past(burnout_enable) && bo_sink_on == bo_src_on;
   endproperty
   a_bo: assert property (p_bo) else $error("burnout pair");
   property p_ref; !sup_reg && !src_reg[1] |-> mod_ref_sel == src_reg; endproperty
   a_ref: assert property (p_ref) else $error("ref select");
   property p_mon;
      supply_mon_on == sup_reg && (!sup_reg || mod_ref_sel == 2'h2);
   endproperty
   a_mon: assert property (p_mon) else $error("supply monitor");
   property p_flag;
      ce && !hit_d |=> missing_reference_flag == $past(bad);
   endproperty
   a_flag: assert property (p_flag) else $error("flag");
   property p_force;
      ce && conv_done && !busy_reg && !hit_d |=> data_vld && !rdy_n &&
      data_out == ($past(missing_reference_flag) ? {DW{1'b1}} : $past(conv_data));
   endproperty
   a_force: assert property (p_force) else $error("result");
   property p_cal_go; s_cal_go |=> rdy_n && !err_flag; endproperty
   a_cal_go: assert property (p_cal_go) else $error("cal start");
   property p_cal_ok;
      s_cal_end ##0 !(seen_reg || missing_reference_flag) |=>
      cal_wr && !rdy_n && !err_flag && cal_wr_data == $past(cal_coef);
   endproperty
   a_cal_ok: assert property (p_cal_ok) else $error("cal end");
   property p_cal_err;
      s_cal_end ##0 (seen_reg || missing_reference_flag) |=> !cal_wr && err_flag;
   endproperty
   a_cal_err: assert property (p_cal_err) else $error("cal error");
   property p_srst; hit_d |=> !bo_src_on && rdy_n && !missing_reference_flag;
   endproperty
   a_srst: assert property (p_srst) else $error("serial reset");
   property p_pulse; hit |-> ##[1:2] soft_rst; endproperty
   a_pulse: assert property (p_pulse) else $error("reset pulse");
   property p_why; $rose(soft_rst) |-> $past(hit) || $past(hit, 2); endproperty
   a_why: assert property (p_why) else $error("stray reset");
endmodule
bind afr_ctrl afr_ctrl_sva #(.DW(DW)) afr_ctrl_sva_i (.*);

// [sim/afr_host.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------
// host model: shifts bits into the serial data input
// ----------------------------------------------------------
module afr_host #(
   parameter RECOV_CYC = 5000   // pause after a reset pattern
) (
   input  wire  clk,            // system clock
   output logic sdi_vld,        // bit strobe
   output logic sdi_bit         // bit value
);
   initial begin
      sdi_vld = 1'b0;
      sdi_bit = 1'b0;
   end
   // n copies of one bit; a released line shows the inverse, not stale
   task automatic shift(input int n, input logic b);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         sdi_vld = 1'b1;
         sdi_bit = b;
      end
      @(negedge clk);
      sdi_vld = 1'b0;
      sdi_bit = ~b;
   endtask
   // no access until the block has settled after a reset
   task automatic recover();
      repeat (RECOV_CYC) @(negedge clk);
   endtask
endmodule

// [sim/tb.sv]
`timescale 1ns/1ns
module tb;
   localparam DW = 24;
   logic clk, arst_n, ce, cfg_wr, burnout_enable, exc_en_in, exc_pin_in;
   logic bias_select_hi, bias_select_lo, bias_fast_power_up, channel_select_hi;
   logic reference_source_hi, reference_source_lo, reference_check_enable;
   logic ref_low_a, ref_low_b, conv_done, cal_start, cal_done, sdi_vld, sdi_bit;
   logic [1:0] exc_mag_in, channel_select_lo, exc_mag, mod_ref_sel;
   logic [2:0] bias_neg_sel;
   logic [DW-1:0] conv_data, cal_coef, data_out, cal_wr_data, d, exp_q[$];
   logic bo_src_on, bo_sink_on, exc_a_on, exc_b_on, bias_bias_fast_power_up, supply_mon_on;
   logic missing_reference_flag, err_flag, rdy_n, data_vld, cal_wr, soft_rst;
   logic [13:0] v;
   logic [4:0] rows[7] = '{5'h16, 5'h0d, 5'h0e, 5'h02, 5'h17, 5'h04, 5'h1f};
   int errors, tests_run, srst_seen;
   afr_ctrl #(.DW(DW)) afr_ctrl_i (.*);
   afr_host afr_host_i (.clk(clk), .sdi_vld(sdi_vld), .sdi_bit(sdi_bit));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // fields: bo, exc en, pin, mag[2], bias[2], bias_fast_power_up, ref[2], det, chan[3]
   task automatic cfg(input logic [13:0] w);
      @(negedge clk);
      {burnout_enable, exc_en_in, exc_pin_in, exc_mag_in, bias_select_hi,
       bias_select_lo, bias_fast_power_up, reference_source_hi,
       reference_source_lo, reference_check_enable, channel_select_hi,
       channel_select_lo} = w;
      cfg_wr = 1'b1;
      @(negedge clk);
      cfg_wr = 1'b0;
   endtask
   task automatic pulse_conv(input logic [DW-1:0] x);
      conv_data = x;
      conv_done = 1'b1;
      @(negedge clk);
      conv_done = 0;
   endtask
   // results: oldest note against each strobe
   always @(negedge clk) begin
      if (data_vld === 1'b1) chk(data_out, exp_q.pop_front());
      if (soft_rst === 1'b1) srst_seen++;
   end
   initial begin
      #2000000;
      errors++;
      tally_and_finish();
   end
   initial begin
      {errors, tests_run, srst_seen, arst_n, ce, ref_low_a, ref_low_b} = 0;
      {conv_done, cal_start, cal_done, conv_data, cal_coef} = 0;
      {burnout_enable, exc_en_in, exc_pin_in, exc_mag_in, bias_select_hi,
       bias_select_lo, bias_fast_power_up, reference_source_hi,
       reference_source_lo, reference_check_enable, channel_select_hi,
       channel_select_lo, cfg_wr} = 0;
      d = $urandom(32'h7f8367b8);
      ce = 1'b1;
      repeat (4) @(negedge clk);
      arst_n = 1'b1;
      @(negedge clk);
      chk({bo_src_on, exc_a_on, exc_b_on, missing_reference_flag, err_flag,
           rdy_n, data_vld, cal_wr, soft_rst, mod_ref_sel}, 11'h020);
      $display("test reset done");
      for (int i = 0; i < 12; i++) begin
         v = $urandom;
         v[8:7] = i % 4;
         v[10:9] = i % 4;
         v[5:4] = i % 4;
         if (i == 11) v[5:0] = 6'h07;
         else if (v[2:0] == 3'h7) v[0] = 1'b0;
         cfg(v);
         chk({bo_src_on, bo_sink_on}, {2{v[13]}});
         chk({exc_a_on, exc_b_on}, {v[12] & ~v[11], v[12] & v[11]});
         chk(exc_mag, v[10:9] == 3 ? 2'h0 : v[10:9]);
         chk(bias_neg_sel, v[8:7] == 0 ? 0 : 3'h1 << (v[8:7] - 1));
         chk(bias_bias_fast_power_up, v[6]);
         chk(mod_ref_sel, v[2:0] == 7 ? 2 : v[5:4]);
         chk(supply_mon_on, v[2:0] == 7);
      end
      ce = 1'b0;
      cfg(~v);
      chk({bo_src_on, bias_bias_fast_power_up}, {v[13], v[6]});
      ce = 1'b1;
      $display("test config done");
      foreach (rows[k]) begin
         cfg({8'h00, rows[k][4:2], 3'h0});
         {ref_low_a, ref_low_b} = rows[k][1:0];
         @(negedge clk);
         v[0] = rows[k][2] && (rows[k][4:3] == 0 ? rows[k][1] :
                rows[k][4:3] == 1 && rows[k][0]);
         chk(missing_reference_flag, v[0]);
         d = $urandom;
         exp_q.push_back(v[0] ? {DW{1'b1}} : d);
         pulse_conv(d);
      end
      $display("test detect done");
      for (int k = 0; k < 2; k++) begin
         cfg(14'h0008);
         ref_low_a = k[0];
         @(negedge clk);
         cal_start = 1'b1;
         @(negedge clk);
         cal_start = 1'b0;
         chk(rdy_n, 1);
         pulse_conv($urandom);
         d = $urandom;
         cal_coef = d;
         cal_done = 1'b1;
         @(negedge clk);
         cal_done = 1'b0;
         chk({cal_wr, err_flag}, {~k[0], k[0]});
         if (k == 0) chk({rdy_n, cal_wr_data}, {1'b0, d});
      end
      ref_low_a = 1'b0;
      $display("test calibration done");
      cfg(14'h2008);
      afr_host_i.shift(31, 1'b1);
      afr_host_i.shift(1, 1'b0);
      afr_host_i.shift(31, 1'b1);
      chk({srst_seen, bo_src_on}, 1);
      afr_host_i.shift(1, 1'b1);
      for (int n = 0; n < 4 && srst_seen == 0; n++) @(negedge clk);
      if (srst_seen == 0) begin
         errors++;
         tally_and_finish();
      end
      chk({srst_seen, bo_src_on, rdy_n}, 5);
      afr_host_i.recover();
      cfg(14'h2000);
      chk(bo_src_on, 1);
      chk(exp_q.size(), 0);
      $display("test serial reset done");
      tally_and_finish();
   end
endmodule
